// ===== common/ddc_defs.vh
`ifndef DDC_DEFS_VH
`define DDC_DEFS_VH

/*
 * Constants for the down-converter front end: register offsets, field positions,
 * reset values, selection and pin codes, decimation codes and latency figures.
 * Assumes inclusion by bare name from every design file that needs them.
 */

// Register offsets, channel A and channel B.
`define DDC_A_SRC_SEL_OFS     16'h500f
`define DDC_A_OSC_CHOICE_OFS  16'h5010
`define DDC_A_PIN_ASSIGN_OFS  16'h5438
`define DDC_B_SRC_SEL_OFS     16'h580f
`define DDC_B_OSC_CHOICE_OFS  16'h5810
`define DDC_B_PIN_ASSIGN_OFS  16'h5c38

// Field positions.
`define DDC_SRC_GPIO_BIT      0
`define DDC_CHOICE_LSB        0
`define DDC_CHOICE_MSB        1
`define DDC_ACTIVE_LSB        4
`define DDC_ACTIVE_MSB        5
`define DDC_BIT0_ASSIGN_LSB   0
`define DDC_BIT0_ASSIGN_MSB   1
`define DDC_BIT1_ASSIGN_LSB   2
`define DDC_BIT1_ASSIGN_MSB   3

// Reset values.
`define DDC_SRC_SEL_RST       1'h0
`define DDC_CHOICE_RST        2'h0
`define DDC_ASSIGN_RST        4'h0

// Control source codes.
`define DDC_SRC_SPI           1'h0
`define DDC_SRC_GPIO          1'h1

// Oscillator choice codes.
`define DDC_OSC_ONE           2'h0
`define DDC_OSC_TWO           2'h1
`define DDC_OSC_THREE         2'h2
`define DDC_OSC_NONE          2'h3
`define DDC_OSC_SECOND_DDC    2'h3

// Pin-assign codes and the GPIO bit index that each selects.
`define DDC_PIN_CODE_GPIO4    2'h0
`define DDC_PIN_CODE_GPIO1    2'h1
`define DDC_PIN_CODE_GPIO3    2'h2
`define DDC_PIN_IDX_GPIO1     2'h0
`define DDC_PIN_IDX_GPIO2     2'h1
`define DDC_PIN_IDX_GPIO3     2'h2
`define DDC_PIN_IDX_GPIO4     2'h3

// Decimation setting codes.
`define DDC_DEC_4             4'h0
`define DDC_DEC_6             4'h1
`define DDC_DEC_8             4'h2
`define DDC_DEC_9             4'h3
`define DDC_DEC_10            4'h4
`define DDC_DEC_12            4'h5
`define DDC_DEC_16            4'h6
`define DDC_DEC_18            4'h7
`define DDC_DEC_20            4'h8
`define DDC_DEC_24            4'h9
`define DDC_DEC_32            4'ha

// Total latency in half device clock cycles (twice the cycle figure).
`define DDC_LAT_BYPASS        12'h350
`define DDC_LAT_DEC_4         12'h408
`define DDC_LAT_DEC_6         12'h5d4
`define DDC_LAT_DEC_8         12'h4da
`define DDC_LAT_DEC_9         12'h5f7
`define DDC_LAT_DEC_10        12'h656
`define DDC_LAT_DEC_12        12'h702
`define DDC_LAT_DEC_16        12'h82a
`define DDC_LAT_DEC_18        12'h918
`define DDC_LAT_DEC_20        12'h9d0
`define DDC_LAT_DEC_24        12'hb46
`define DDC_LAT_DEC_32        12'hdda
`define DDC_LAT_UNKNOWN       12'h000

// Sine table full-scale value at a quarter turn.
`define DDC_SINE_PEAK         16'h7fff
`define DDC_QUARTER_STEPS     5'h10

`endif

// ===== hdl/ddc_nco_mixer.v
/*
 * Digital down-conversion front end for two converter channels: eight phase
 * accumulators with sine lookup, complex mixers for two down-converters per
 * channel, oscillator switching by register or GPIO, a single-channel input
 * multiplexer, a latency report and a two-entry output buffer.
 * Assumes samples and register accesses arrive on clock; GPIO pins are
 * asynchronous and are synchronised here.
 */
// Functional notes
// RULE_01: Each oscillator makes a complex exponential from a signed 16-bit frequency word.
// RULE_02: Mixer multiplies the real sample by the exponential, moving the carrier to 0 Hz.
// RULE_03: Each channel has two down-converters: three oscillators, then one oscillator.
// RULE_04: First down-converter switches oscillators at run time, by register or GPIO.
// RULE_05: Wide-bandwidth mode with low decimation offers only one down-converter per channel.
// RULE_06: Output frequency equals frequency word times sample rate over two to sixteen.
// RULE_07: Changes during a running link make phase unknown; link restart realigns phase.
// RULE_08: Oscillator switching works in single and dual band, only on first down-converter.
// RULE_09: Per-channel source setting picks register (default) or GPIO oscillator control.
// RULE_10: Pin-assign codes 00,01,10,11 pick GPIO pins 4,1,3,2 for each selection bit.
// RULE_11: Selection codes 00,01,10 pick oscillators one, two, three; 11 is unassigned.
// RULE_12: Single-channel mode feeds channel A samples to both paths; B may power down.
// RULE_13: Multiplexed operation keeps decimation and link format as in dual operation.
// RULE_14: Bypass in 12-bit mode with LMFS 8224 gives 424 device clock cycles latency.
// RULE_15: Enabled down-conversion latency depends on decimation, 516 up to 1773 cycles.
// RULE_16: Each oscillator phase accumulator adds its word every sample, wrapping at 2^16.
// RULE_17: Unassigned selection code 11 keeps the previously selected oscillator.
`timescale 1ns/1ns
`include "ddc_defs.vh"

module ddc_nco_mixer #(
	parameter SAMPLE_W = 14,
	parameter OUT_W    = 16,
	parameter FREQ_W   = 16,
	parameter BUF_W    = 8 * 16
) (
	input  wire                      clock,
	input  wire                      rst_n,
	input  wire [SAMPLE_W-1:0]       sample_a,
	input  wire [SAMPLE_W-1:0]       sample_b,
	input  wire                      sample_valid,
	output wire                      sample_ready,
	input  wire [4*FREQ_W-1:0]       freq_word_a,
	input  wire [4*FREQ_W-1:0]       freq_word_b,
	input  wire                      single_channel,
	input  wire                      wide_band,
	input  wire                      ddc_bypass,
	input  wire [3:0]                decim_code,
	input  wire                      link_restart,
	input  wire [3:0]                gpio_in,
	input  wire [15:0]               reg_addr,
	input  wire [7:0]                reg_wdata,
	input  wire                      reg_wr,
	output reg  [7:0]                reg_rdata_q,
	output wire [BUF_W-1:0]          out_data,
	output wire                      out_valid,
	input  wire                      out_ready,
	output reg                       chan_b_power_down_q,
	output reg  [11:0]               latency_half_q,
	output wire [3:0]                active_osc
);

	localparam PROD_W  = SAMPLE_W + 16;
	localparam OUT_MSB = SAMPLE_W + 14;

	// Quarter-wave sine, 16 steps per quarter turn, value at k of 16.
	function [15:0] quarter;
		input [4:0] k;
		begin
			case (k)
			5'h00: quarter = 16'h0000;
			5'h01: quarter = 16'h0c8c;
			5'h02: quarter = 16'h18f9;
			5'h03: quarter = 16'h2528;
			5'h04: quarter = 16'h30fb;
			5'h05: quarter = 16'h3c56;
			5'h06: quarter = 16'h471c;
			5'h07: quarter = 16'h5133;
			5'h08: quarter = 16'h5a82;
			5'h09: quarter = 16'h62f1;
			5'h0a: quarter = 16'h6a6d;
			5'h0b: quarter = 16'h70e2;
			5'h0c: quarter = 16'h7641;
			5'h0d: quarter = 16'h7a7c;
			5'h0e: quarter = 16'h7d89;
			5'h0f: quarter = 16'h7f61;
			default: quarter = `DDC_SINE_PEAK;
			endcase
		end
	endfunction

	// Signed sine of the top six phase bits.
	function [15:0] sine6;
		input [5:0] ph;
		reg [4:0] idx;
		begin
			idx = {1'b0, ph[3:0]};
			case (ph[5:4])
			2'h0: sine6 = quarter(idx);
			2'h1: sine6 = quarter(`DDC_QUARTER_STEPS - idx);
			2'h2: sine6 = 16'h0000 - quarter(idx);
			default: sine6 = 16'h0000 - quarter(`DDC_QUARTER_STEPS - idx);
			endcase
		end
	endfunction

	// GPIO pin index chosen by a pin-assign code.
	function [1:0] pin_index;
		input [1:0] code;
		begin
			case (code)
			`DDC_PIN_CODE_GPIO4: pin_index = `DDC_PIN_IDX_GPIO4;
			`DDC_PIN_CODE_GPIO1: pin_index = `DDC_PIN_IDX_GPIO1;
			`DDC_PIN_CODE_GPIO3: pin_index = `DDC_PIN_IDX_GPIO3;
			default: pin_index = `DDC_PIN_IDX_GPIO2;
			endcase
		end
	endfunction

	reg  [3:0]          gpio_meta_q;
	reg  [3:0]          gpio_sync_q;
	reg  [1:0]          src_q [0:1];
	reg  [1:0]          choice_q [0:1];
	reg  [3:0]          assign_q [0:1];
	reg  [1:0]          active_q [0:1];
	wire                take;
	wire                buf_in_ready;
	wire [FREQ_W-1:0]   phase [0:7];
	wire [BUF_W/2-1:0]  chan_word [0:1];

	assign take         = sample_valid && buf_in_ready;
	assign sample_ready = buf_in_ready;
	assign active_osc   = {active_q[1], active_q[0]};

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gpio_meta_q <= 4'h0;
			gpio_sync_q <= 4'h0;
		end else begin
			gpio_meta_q <= gpio_in;
			gpio_sync_q <= gpio_meta_q;
		end
	end

	// Eight oscillators: index ch*4 + n, n = 0..2 first down-converter, 3 second.
	genvar k;
	generate
		for (k = 0; k < 8; k = k + 1) begin : g_nco
			reg  [FREQ_W-1:0] acc_q;
			wire [FREQ_W-1:0] word;
			if (k < 4) begin : g_a
				assign word = freq_word_a[(k%4)*FREQ_W +: FREQ_W];
			end else begin : g_b
				assign word = freq_word_b[(k%4)*FREQ_W +: FREQ_W];
			end
			always @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					acc_q <= {FREQ_W{1'b0}};
				end else if (link_restart) begin
					acc_q <= {FREQ_W{1'b0}}; // RULE_07
				end else if (take) begin
					acc_q <= acc_q + word; // RULE_16 RULE_06 RULE_01
				end
			end
			assign phase[k] = acc_q;
		end
	endgenerate

	// Per-channel selection, mixing and output word.
	genvar c;
	generate
		for (c = 0; c < 2; c = c + 1) begin : g_chan
			wire [1:0]          code;
			wire                bit0;
			wire                bit1;
			wire [FREQ_W-1:0]   ph0;
			wire [FREQ_W-1:0]   ph1;
			wire [SAMPLE_W-1:0] x;
			wire [15:0]         cos0;
			wire [15:0]         sin0;
			wire [15:0]         cos1;
			wire [15:0]         sin1;
			wire [PROD_W-1:0]   pi0;
			wire [PROD_W-1:0]   pq0;
			wire [PROD_W-1:0]   pi1;
			wire [PROD_W-1:0]   pq1;
			wire [OUT_W-1:0]    i1;
			wire [OUT_W-1:0]    q1;

			assign bit0 = gpio_sync_q[pin_index(assign_q[c][`DDC_BIT0_ASSIGN_MSB:
				`DDC_BIT0_ASSIGN_LSB])]; // RULE_10
			assign bit1 = gpio_sync_q[pin_index(assign_q[c][`DDC_BIT1_ASSIGN_MSB:
				`DDC_BIT1_ASSIGN_LSB])]; // RULE_10
			assign code = (src_q[c][`DDC_SRC_GPIO_BIT] == `DDC_SRC_GPIO) ?
				{bit1, bit0} : choice_q[c]; // RULE_09 RULE_04

			always @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					active_q[c] <= `DDC_OSC_ONE;
				end else if (code != `DDC_OSC_NONE) begin // RULE_17
					active_q[c] <= code; // RULE_11 RULE_08
				end
			end

			// Channel B path takes channel A samples in single-channel mode.
			assign x = (c == 1 && !single_channel) ? sample_b : sample_a; // RULE_12

			assign ph0 = phase[c*4 + active_q[c]]; // RULE_03 RULE_04
			assign ph1 = phase[c*4 + `DDC_OSC_SECOND_DDC]; // RULE_03 RULE_08
			assign sin0 = sine6(ph0[FREQ_W-1 -: 6]);
			assign cos0 = sine6(ph0[FREQ_W-1 -: 6] + 6'h10);
			assign sin1 = sine6(ph1[FREQ_W-1 -: 6]);
			assign cos1 = sine6(ph1[FREQ_W-1 -: 6] + 6'h10);

			// x * exp(-jwn): I = x cos, Q = -x sin.
			assign pi0 = $signed(x) * $signed(cos0); // RULE_02
			assign pq0 = $signed(x) * $signed(16'h0000 - sin0); // RULE_02
			assign pi1 = $signed(x) * $signed(cos1);
			assign pq1 = $signed(x) * $signed(16'h0000 - sin1);

			// Wide-bandwidth mode leaves the second down-converter silent.
			assign i1 = wide_band ? {OUT_W{1'b0}} : pi1[OUT_MSB -: OUT_W]; // RULE_05
			assign q1 = wide_band ? {OUT_W{1'b0}} : pq1[OUT_MSB -: OUT_W]; // RULE_05

			assign chan_word[c] = {pi0[OUT_MSB -: OUT_W], pq0[OUT_MSB -: OUT_W], i1, q1};
		end
	endgenerate

	// Register writes.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			src_q[0]    <= {1'b0, `DDC_SRC_SEL_RST};
			src_q[1]    <= {1'b0, `DDC_SRC_SEL_RST};
			choice_q[0] <= `DDC_CHOICE_RST;
			choice_q[1] <= `DDC_CHOICE_RST;
			assign_q[0] <= `DDC_ASSIGN_RST;
			assign_q[1] <= `DDC_ASSIGN_RST;
		end else if (reg_wr) begin
			if (reg_addr == `DDC_A_SRC_SEL_OFS) begin
				src_q[0] <= {1'b0, reg_wdata[`DDC_SRC_GPIO_BIT]}; // RULE_09
			end else if (reg_addr == `DDC_A_OSC_CHOICE_OFS) begin
				choice_q[0] <= reg_wdata[`DDC_CHOICE_MSB:`DDC_CHOICE_LSB];
			end else if (reg_addr == `DDC_A_PIN_ASSIGN_OFS) begin
				assign_q[0] <= reg_wdata[`DDC_BIT1_ASSIGN_MSB:`DDC_BIT0_ASSIGN_LSB];
			end else if (reg_addr == `DDC_B_SRC_SEL_OFS) begin
				src_q[1] <= {1'b0, reg_wdata[`DDC_SRC_GPIO_BIT]}; // RULE_09
			end else if (reg_addr == `DDC_B_OSC_CHOICE_OFS) begin
				choice_q[1] <= reg_wdata[`DDC_CHOICE_MSB:`DDC_CHOICE_LSB];
			end else if (reg_addr == `DDC_B_PIN_ASSIGN_OFS) begin
				assign_q[1] <= reg_wdata[`DDC_BIT1_ASSIGN_MSB:`DDC_BIT0_ASSIGN_LSB];
			end
		end
	end

	// Register reads, one cycle behind the address; unmapped reads give zero.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_addr == `DDC_A_SRC_SEL_OFS) begin
			reg_rdata_q <= {7'h00, src_q[0][`DDC_SRC_GPIO_BIT]};
		end else if (reg_addr == `DDC_A_OSC_CHOICE_OFS) begin
			reg_rdata_q <= {2'h0, active_q[0], 2'h0, choice_q[0]};
		end else if (reg_addr == `DDC_A_PIN_ASSIGN_OFS) begin
			reg_rdata_q <= {4'h0, assign_q[0]};
		end else if (reg_addr == `DDC_B_SRC_SEL_OFS) begin
			reg_rdata_q <= {7'h00, src_q[1][`DDC_SRC_GPIO_BIT]};
		end else if (reg_addr == `DDC_B_OSC_CHOICE_OFS) begin
			reg_rdata_q <= {2'h0, active_q[1], 2'h0, choice_q[1]};
		end else if (reg_addr == `DDC_B_PIN_ASSIGN_OFS) begin
			reg_rdata_q <= {4'h0, assign_q[1]};
		end else begin
			reg_rdata_q <= 8'h00;
		end
	end

	// Latency report and channel B power-down.
	reg [11:0] latency_half_d;
	always @* begin
		latency_half_d = `DDC_LAT_UNKNOWN;
		if (ddc_bypass) begin
			latency_half_d = `DDC_LAT_BYPASS; // RULE_14
		end else begin
			case (decim_code) // RULE_15
			`DDC_DEC_4:  latency_half_d = `DDC_LAT_DEC_4;
			`DDC_DEC_6:  latency_half_d = `DDC_LAT_DEC_6;
			`DDC_DEC_8:  latency_half_d = `DDC_LAT_DEC_8;
			`DDC_DEC_9:  latency_half_d = `DDC_LAT_DEC_9;
			`DDC_DEC_10: latency_half_d = `DDC_LAT_DEC_10;
			`DDC_DEC_12: latency_half_d = `DDC_LAT_DEC_12;
			`DDC_DEC_16: latency_half_d = `DDC_LAT_DEC_16;
			`DDC_DEC_18: latency_half_d = `DDC_LAT_DEC_18;
			`DDC_DEC_20: latency_half_d = `DDC_LAT_DEC_20;
			`DDC_DEC_24: latency_half_d = `DDC_LAT_DEC_24;
			`DDC_DEC_32: latency_half_d = `DDC_LAT_DEC_32;
			default:     latency_half_d = `DDC_LAT_UNKNOWN;
			endcase
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			latency_half_q      <= `DDC_LAT_UNKNOWN;
			chan_b_power_down_q <= 1'b0;
		end else begin
			// Latency does not depend on the multiplexer setting.
			latency_half_q      <= latency_half_d; // RULE_13
			chan_b_power_down_q <= single_channel; // RULE_12
		end
	end

	// Two-entry output buffer; the same word layout in both mux settings.
	reg  [BUF_W-1:0] buf_q [0:1];
	reg              wr_ptr_q;
	reg              rd_ptr_q;
	reg  [1:0]       count_q;
	wire             push;
	wire             pop;

	assign buf_in_ready = (count_q != 2'h2);
	assign out_valid    = (count_q != 2'h0);
	assign out_data     = buf_q[rd_ptr_q];
	assign push         = take;
	assign pop          = out_valid && out_ready;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			buf_q[0] <= {BUF_W{1'b0}};
			buf_q[1] <= {BUF_W{1'b0}};
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q  <= 2'h0;
		end else begin
			if (push) begin
				buf_q[wr_ptr_q] <= {chan_word[0], chan_word[1]}; // RULE_13
				wr_ptr_q        <= ~wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			if (push && !pop) begin
				count_q <= count_q + 2'h1;
			end else if (pop && !push) begin
				count_q <= count_q - 2'h1;
			end
		end
	end

endmodule // ddc_nco_mixer

// ===== tb/ddc_nco_mixer_chk.sv
/* Port-level assertions for the down-converter front end.
   Bound to the top module from the bench; sees only its ports. */
`timescale 1ns/1ns
module ddc_nco_mixer_chk #(
	parameter BUF_W = 128
) (
	input wire             clock,
	input wire             rst_n,
	input wire             sample_valid,
	input wire             sample_ready,
	input wire             single_channel,
	input wire             ddc_bypass,
	input wire [3:0]       decim_code,
	input wire [15:0]      reg_addr,
	input wire [7:0]       reg_wdata,
	input wire             reg_wr,
	input wire [7:0]       reg_rdata_q,
	input wire [BUF_W-1:0] out_data,
	input wire             out_valid,
	input wire             out_ready,
	input wire             chan_b_power_down_q,
	input wire [11:0]      latency_half_q,
	input wire [3:0]       active_osc
);
	localparam [131:0] LAT = 132'hddab469d091882a7026565f74da5d4408;
	reg       up_q;
	reg       src_a_q;
	reg [1:0] cnt_q;
	wire      ch_wr = reg_wr && reg_addr == 16'h5010 && !src_a_q;
	function [11:0] lat(input b, input [3:0] d);
		lat = b ? 12'h350 : (d < 4'hb ? LAT[d*12 +: 12] : 12'h000);
	endfunction
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			up_q    <= 1'b0;
			src_a_q <= 1'b0;
			cnt_q   <= 2'h0;
		end else begin
			up_q  <= 1'b1;
			cnt_q <= cnt_q + {1'b0, sample_valid && sample_ready} - {1'b0, out_valid && out_ready};
			if (reg_wr && reg_addr == 16'h500f)
				src_a_q <= reg_wdata[0];
		end
	end
	a_ready_full: assert property (sample_ready == (cnt_q != 2'h2))
		else $error("sample_ready disagrees with fill");
	a_valid_fill: assert property (out_valid == (cnt_q != 2'h0))
		else $error("out_valid disagrees with fill");
	a_word_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("word changed before acceptance");
	a_latency_map: assert property (
		up_q |-> latency_half_q == lat($past(ddc_bypass), $past(decim_code)))
		else $error("latency figure wrong");
	a_power_down: assert property (
		up_q |-> chan_b_power_down_q == $past(single_channel))
		else $error("power down does not follow mode");
	a_spi_choice: assert property (
		ch_wr && reg_wdata[1:0] != 2'h3 |-> ##2 active_osc[1:0] == $past(reg_wdata[1:0], 2))
		else $error("register choice not applied");
	a_code_keeps: assert property (
		ch_wr && reg_wdata[1:0] == 2'h3 |=> $stable(active_osc[1:0]) [*2])
		else $error("unassigned code changed oscillator");
	a_osc_legal: assert property (
		active_osc[1:0] != 2'h3 && active_osc[3:2] != 2'h3)
		else $error("no such oscillator");
	a_unmapped_rd: assert property (up_q && $past(reg_addr[15:8]) == 8'h51 |-> reg_rdata_q == 8'h00)
		else $error("unmapped read not zero");
endmodule // ddc_nco_mixer_chk

// ===== tb/ddc_nco_mixer_tb.sv
/* Self-checking bench for the down-converter front end.
   Inputs change on the falling edge; the receiver model paces the output. */
`timescale 1ns/1ns
module ddc_nco_mixer_tb;
	localparam [95:0] ADDRS = {16'h5c38, 16'h5810, 16'h580f, 16'h5438, 16'h5010, 16'h500f};
	localparam [7:0]  PIN   = {2'h1, 2'h2, 2'h0, 2'h3};
	localparam [131:0] LAT  = 132'hddab469d091882a7026565f74da5d4408;
	reg          clock, rst_n, sample_valid, single_channel, wide_band, ddc_bypass;
	reg          link_restart, reg_wr, hold;
	reg  [13:0]  sample_a, sample_b;
	reg  [63:0]  freq_word_a, freq_word_b;
	reg  [3:0]   decim_code, gpio_in;
	reg  [15:0]  reg_addr;
	reg  [7:0]   reg_wdata;
	wire         sample_ready, out_valid, out_ready, chan_b_power_down_q;
	wire [7:0]   reg_rdata_q;
	wire [127:0] out_data;
	wire [11:0]  latency_half_q;
	wire [3:0]   active_osc;
	integer      bad_count, checks, cyc, n, i, c;
	reg  [31:0]  rs;
	reg  [1:0]   ca, cb;
	reg  [11:0]  lat_e;
	reg  [127:0] exp_q[$];
	ddc_nco_mixer dut_u (.clock(clock), .rst_n(rst_n), .sample_a(sample_a), .sample_b(sample_b),
		.sample_valid(sample_valid), .sample_ready(sample_ready), .freq_word_a(freq_word_a),
		.freq_word_b(freq_word_b), .single_channel(single_channel), .wide_band(wide_band),
		.ddc_bypass(ddc_bypass), .decim_code(decim_code), .link_restart(link_restart),
		.gpio_in(gpio_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rdata_q(reg_rdata_q), .out_data(out_data), .out_valid(out_valid),
		.out_ready(out_ready), .chan_b_power_down_q(chan_b_power_down_q),
		.latency_half_q(latency_half_q), .active_osc(active_osc));
	ddc_rx_model rx_u (.clock(clock), .rst_n(rst_n), .hold(hold), .out_ready(out_ready));
	function [31:0] xs(input [31:0] v);
		reg [31:0] t;
		begin
			t = v ^ (v << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	function signed [17:0] sn(input [1:0] k);
		sn = k[0] ? (k[1] ? -18'sd32767 : 18'sd32767) : 18'sd0;
	endfunction
	function [15:0] mx(input [13:0] x, input [15:0] ph, input qd);
		reg signed [31:0] p;
		begin
			p = $signed(x) * (qd ? -sn(ph[15:14]) : sn(ph[15:14] + 2'h1));
			mx = p[28:13];
		end
	endfunction
	function [63:0] ch(input [13:0] x, input [63:0] fw, input [1:0] s);
		reg [15:0] p1, p2;
		begin
			p1 = n * fw[s*16 +: 16];
			p2 = n * fw[63:48];
			ch = {mx(x, p1, 1'b0), mx(x, p1, 1'b1), wide_band ? 32'h0 : {mx(x, p2, 1'b0), mx(x, p2, 1'b1)}};
		end
	endfunction
	task automatic chk(input string nm, input [127:0] e, input [127:0] s);
		begin
			checks = checks + 1;
			if (s !== e) begin
				bad_count = bad_count + 1;
				$display("CHECK FAILED %0s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	task wr(input [15:0] a, input [7:0] d);
		begin
			@(negedge clock) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
			@(negedge clock) reg_wr = 1'b0;
		end
	endtask
	task rd(input [15:0] a, input [7:0] e);
		begin
			@(negedge clock) reg_addr = a;
			@(negedge clock) chk("reg_rdata_q", e, reg_rdata_q);
		end
	endtask
	task pins(input [3:0] g, input [1:0] e);
		begin
			@(negedge clock) gpio_in = g;
			repeat (4) @(negedge clock);
			chk("active_osc", e, active_osc[1:0]);
		end
	endtask
	task send(input [13:0] xa, input [13:0] xb);
		reg r;
		begin
			r = 1'b0;
			while (!r) begin
				@(negedge clock) {sample_a, sample_b, sample_valid} = {xa, xb, 1'b1};
				r = sample_ready;
				@(posedge clock);
			end
			exp_q.push_back({ch(xa, freq_word_a, ca), ch(single_channel ? xa : xb, freq_word_b, cb)});
			n = n + 1;
		end
	endtask
	task batch(input integer k);
		integer j;
		begin
			for (j = 0; j < k; j = j + 1) begin
				rs = xs(rs);
				send(rs[13:0], rs[29:16]);
			end
			@(negedge clock) sample_valid = 1'b0;
			for (j = 0; j < 300 && exp_q.size() != 0; j = j + 1)
				@(negedge clock);
			chk("exp_q drained", 128'h0, exp_q.size());
		end
	endtask
	task restart;
		begin
			@(negedge clock) link_restart = 1'b1;
			repeat (2) @(negedge clock);
			link_restart = 1'b0;
			n = 0;
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", checks, bad_count);
			if (bad_count == 0 && checks > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) begin
		if (rst_n === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
			if (exp_q.size() == 0)
				chk("out_data surplus", 128'h0, 128'h1);
			else
				chk("out_data", exp_q.pop_front(), out_data);
		end
	end
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 6000) begin
			bad_count = bad_count + 1;
			complete_run;
		end
	end
	initial begin
		{sample_valid, single_channel, wide_band, ddc_bypass, link_restart, reg_wr, hold} = 7'h00;
		{sample_a, sample_b, decim_code, gpio_in, reg_addr, reg_wdata} = 60'h0;
		freq_word_a = {16'hc000, 16'h0000, 16'h8000, 16'h4000};
		freq_word_b = {16'h4000, 16'h8000, 16'hc000, 16'h0000};
		{bad_count, checks, cyc, n} = 128'h0;
		{rs, ca, cb} = {32'h0000003f, 4'h0};
		rst_n = 1'b0;
		repeat (4) @(posedge clock);
		@(negedge clock) rst_n = 1'b1;
		for (i = 0; i < 6; i = i + 1)
			rd(ADDRS[i*16 +: 16], 8'h00);
		rd(16'h5111, 8'h00);
		$display("test reset done");
		for (i = 0; i < 4; i = i + 1) begin
			wr(16'h5010, i[7:0]);
			ca = (i < 3) ? i[1:0] : ca;
			rd(16'h5010, {2'h0, ca, 2'h0, i[1:0]});
		end
		wr(16'h5810, 8'h02);
		cb = 2'h2;
		rd(16'h5810, 8'h22);
		$display("test select done");
		restart;
		batch(6);
		wr(16'h5010, 8'h01);
		ca = 2'h1;
		repeat (3) @(negedge clock);
		batch(6);
		$display("test hopping done");
		hold <= 1'b1;
		repeat (2) @(negedge clock);
		send(14'h1000, 14'h3000);
		send(14'h2abc, 14'h0155);
		@(negedge clock) sample_valid = 1'b0;
		fork
			send(14'h0777, 14'h3fff);
			begin
				repeat (3) @(negedge clock);
				chk("sample_ready", 128'h0, sample_ready);
				hold <= 1'b0;
			end
		join
		batch(0);
		chk("out_valid", 128'h0, out_valid);
		$display("test buffer done");
		{wide_band, single_channel} = 2'h3;
		restart;
		batch(5);
		chk("chan_b_power_down_q", 128'h1, chan_b_power_down_q);
		{wide_band, single_channel} = 2'h0;
		$display("test single wide done");
		wr(16'h500f, 8'h01);
		for (c = 0; c < 4; c = c + 1) begin
			wr(16'h5438, {4'h0, c[1:0] ^ 2'h1, c[1:0]});
			pins(4'h1 << PIN[c*2 +: 2], 2'h1);
			pins(4'h1 << PIN[(c^1)*2 +: 2], 2'h2);
			pins(4'hf, 2'h2);
		end
		$display("test gpio done");
		chk("chan_b_power_down_q", 128'h0, chan_b_power_down_q);
		for (i = 0; i < 13; i = i + 1) begin
			@(negedge clock) {decim_code, ddc_bypass} = {i[3:0], i == 12};
			repeat (2) @(negedge clock);
			lat_e = (i == 12) ? 12'h350 : ((i < 11) ? LAT[i*12 +: 12] : 12'h000);
			chk("latency_half_q", lat_e, latency_half_q);
		end
		$display("test latency done");
		complete_run;
	end
endmodule // ddc_nco_mixer_tb
bind ddc_nco_mixer ddc_nco_mixer_chk #(.BUF_W(BUF_W)) chk_u (.clock(clock), .rst_n(rst_n),
	.sample_valid(sample_valid), .sample_ready(sample_ready), .single_channel(single_channel),
	.ddc_bypass(ddc_bypass), .decim_code(decim_code), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata_q(reg_rdata_q), .out_data(out_data),
	.out_valid(out_valid), .out_ready(out_ready), .chan_b_power_down_q(chan_b_power_down_q),
	.latency_half_q(latency_half_q), .active_osc(active_osc));

// ===== tb/ddc_rx_model.sv
/* Receiver at the far end of the output buffer.
   Stalls in a pseudo-random pattern; hold stalls it fully. */
`timescale 1ns/1ns
module ddc_rx_model (
	input  wire clock,
	input  wire rst_n,
	input  wire hold,
	output reg  out_ready
);
	reg [7:0] lfsr_q;
	always @(negedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lfsr_q    <= 8'h5a;
			out_ready <= 1'b0;
		end else begin
			lfsr_q    <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
			out_ready <= !hold && (lfsr_q[0] || lfsr_q[1]);
		end
	end
endmodule // ddc_rx_model
